// File: gpb_consts.vh
// Constants for the GPIO port block: map, fields, modes, reset values
`ifndef GPB_CONSTS_VH
`define GPB_CONSTS_VH

// Geometry
`define GPB_NPORTS 8
`define GPB_NPINS 55
`define GPB_PINS_ALL 64

// Register index within a port window (byte address bits [4:2])
`define GPB_REG_DR 3'h0
`define GPB_REG_PS 3'h1
`define GPB_REG_DM 3'h2
`define GPB_REG_CFG 3'h3
`define GPB_REG_HOLD 3'h4
`define GPB_REG_MSK 3'h5
`define GPB_REG_STAT 3'h6
`define GPB_REG_SEL 3'h7

// Port window: byte address bits [7:5] pick the port, stride 0x20
`define GPB_PORT_LSB 5
`define GPB_REG_LSB 2
`define GPB_MAP_LSB 8

// Field positions inside the configuration word
`define GPB_CFG_INDIS_LSB 0
`define GPB_CFG_OUTDIS_LSB 8
`define GPB_CFG_LVTTL_LSB 16
`define GPB_CFG_SLOW_LSB 24

// Drive modes, four bits per pin; unknown codes behave as disabled
`define GPB_DM_DIS 4'h0
`define GPB_DM_INONLY 4'h1
`define GPB_DM_STRONG 4'h2
`define GPB_DM_RPU 4'h3
`define GPB_DM_RPD 4'h4
`define GPB_DM_WPU 4'h5
`define GPB_DM_WPD 4'h6
`define GPB_DM_OD 4'h7
`define GPB_DM_OS 4'h8

// Reset values
`define GPB_RST_BYTE 8'h00
`define GPB_RST_WORD 32'h00000000

// Bus answers
`define GPB_RESP_OKAY 2'h0
`define GPB_RESP_SLVERR 2'h2

`endif

// File: gpb_top.v
// GPIO port block: pad control, I/O matrix, pin state, interrupts, AXI4-Lite
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpb_consts.vh"
module gpb_top #(
	parameter NPINS = `GPB_NPINS,
	parameter AW = 12
) (
	input wire clk_i,
	input wire rst_i,
	input wire [AW-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [AW-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire sleep_hold_i,
	input wire [NPINS-1:0] pad_in_i,
	output reg [NPINS-1:0] pad_out_o,
	output reg [NPINS-1:0] pad_oe_n_o,
	output reg [NPINS-1:0] pad_pu_o,
	output reg [NPINS-1:0] pad_pd_o,
	output reg [NPINS-1:0] pad_weak_o,
	output reg [NPINS-1:0] pad_ie_o,
	output reg [NPINS-1:0] pad_lvttl_o,
	output reg [NPINS-1:0] pad_slow_o,
	input wire [NPINS-1:0] periph_out_i,
	input wire [NPINS-1:0] periph_oe_i,
	output wire [NPINS-1:0] periph_in_o,
	output wire [`GPB_NPORTS-1:0] port_irq_o,
	output wire irq_o
);

	localparam NALL = `GPB_PINS_ALL;

	// Per-port register arrays
	reg [7:0] dr [0:`GPB_NPORTS-1];
	reg [31:0] dm [0:`GPB_NPORTS-1];
	reg [7:0] indis [0:`GPB_NPORTS-1];
	reg [7:0] outdis [0:`GPB_NPORTS-1];
	reg [7:0] lvttl [0:`GPB_NPORTS-1];
	reg [7:0] slow [0:`GPB_NPORTS-1];
	reg [7:0] hold [0:`GPB_NPORTS-1];
	reg [7:0] msk [0:`GPB_NPORTS-1];
	reg [7:0] stat [0:`GPB_NPORTS-1];
	reg [7:0] sel [0:`GPB_NPORTS-1];

	// Flattened views, one bit (or nibble) per pin
	wire [NALL-1:0] dr_f;
	wire [4*NALL-1:0] dm_f;
	wire [NALL-1:0] indis_f;
	wire [NALL-1:0] outdis_f;
	wire [NALL-1:0] lvttl_f;
	wire [NALL-1:0] slow_f;
	wire [NALL-1:0] hold_f;
	wire [NALL-1:0] sel_f;
	wire [NALL-1:0] ps_f;

	// Pin-side signals widened to a full set of eight ports
	wire [NALL-1:0] pin_ext;
	wire [NALL-1:0] pout_ext;
	wire [NALL-1:0] poe_ext;
	reg [NALL-1:0] sync1;
	reg [NALL-1:0] sync2;
	reg [NALL-1:0] sync3;
	reg [NALL-1:0] ps;
	wire [NALL-1:0] agree;
	wire [NALL-1:0] next_ps;
	wire [NALL-1:0] evt;

	// Next pad values computed per pin
	wire [NALL-1:0] next_out;
	wire [NALL-1:0] next_oe;
	wire [NALL-1:0] next_pu;
	wire [NALL-1:0] next_pd;
	wire [NALL-1:0] next_weak;
	wire [NALL-1:0] next_ie;
	wire [NALL-1:0] upd;

	// Bus slave state
	reg aw_got;
	reg w_got;
	reg [AW-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [31:0] cur_word;
	reg [31:0] rd_word;
	wire do_wr;
	wire wmap;
	wire rmap;
	wire [2:0] wp;
	wire [2:0] wr;
	wire [2:0] rp;
	wire [2:0] rr;
	wire [31:0] wv;

	integer k;
	integer kc;
	integer ks;

	// Pins that exist; absent ones keep no state and read back zero
	wire [NALL-1:0] pres;
	wire [4*NALL-1:0] pres4;
	wire [7:0] wpm;
	wire [31:0] wdm;

	assign pin_ext = {{(NALL-NPINS){1'b0}}, pad_in_i};
	assign pout_ext = {{(NALL-NPINS){1'b0}}, periph_out_i};
	assign poe_ext = {{(NALL-NPINS){1'b0}}, periph_oe_i};
	assign pres = {{(NALL-NPINS){1'b0}}, {NPINS{1'b1}}};
	assign wpm = pres[wp*8+:8];
	assign wdm = pres4[wp*32+:32];

	// Per-port flattening and port interrupt request
	genvar p;
	generate
		for (p = 0; p < `GPB_NPORTS; p = p + 1) begin : g_port
			assign dr_f[p*8+:8] = dr[p];
			assign dm_f[p*32+:32] = dm[p];
			assign indis_f[p*8+:8] = indis[p];
			assign outdis_f[p*8+:8] = outdis[p];
			assign lvttl_f[p*8+:8] = lvttl[p];
			assign slow_f[p*8+:8] = slow[p];
			assign hold_f[p*8+:8] = hold[p];
			assign sel_f[p*8+:8] = sel[p];
			assign port_irq_o[p] = |(stat[p] & msk[p]);
		end
	endgenerate

	assign irq_o = |port_irq_o;

	// Drive decode per pin; matrix picks the data source first
	genvar i;
	generate
		for (i = 0; i < NALL; i = i + 1) begin : g_pin
			reg d;
			reg oe;
			reg o;
			reg pu;
			reg pd;
			reg wk;
			reg ie;
			always @* begin
				d = sel_f[i] ? pout_ext[i] : dr_f[i];
				oe = 1'b0;
				o = 1'b0;
				pu = 1'b0;
				pd = 1'b0;
				wk = 1'b0;
				ie = 1'b1;
				case (dm_f[i*4+:4])
				`GPB_DM_STRONG: begin
					oe = 1'b1;
					o = d;
				end
				`GPB_DM_RPU: begin
					oe = ~d;
					pu = 1'b1;
				end
				`GPB_DM_RPD: begin
					oe = d;
					o = 1'b1;
					pd = 1'b1;
				end
				`GPB_DM_WPU: begin
					oe = ~d;
					pu = 1'b1;
					wk = 1'b1;
				end
				`GPB_DM_WPD: begin
					oe = d;
					o = 1'b1;
					pd = 1'b1;
					wk = 1'b1;
				end
				`GPB_DM_OD: begin
					oe = ~d;
				end
				`GPB_DM_OS: begin
					oe = d;
					o = 1'b1;
				end
				`GPB_DM_INONLY: begin
					oe = 1'b0;
				end
				default: begin
					ie = 1'b0;
				end
				endcase
			end
			// Peripheral enable on matrix-selected pins and output disable both veto the driver
			assign next_oe[i] = oe & ~outdis_f[i]
				& (~sel_f[i] | poe_ext[i]);
			assign next_out[i] = o;
			assign next_pu[i] = pu;
			assign next_pd[i] = pd;
			assign next_weak[i] = wk;
			assign next_ie[i] = ie & ~indis_f[i];
			assign pres4[i*4+:4] = {4{pres[i]}};
		end
	endgenerate

	// Held pins keep their last pad state while the sleep request stands
	assign upd = ~(hold_f & {NALL{sleep_hold_i}});

	// Pad outputs; reset leaves every pin undriven and unloaded
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pad_out_o <= {NPINS{1'b0}};
			pad_oe_n_o <= {NPINS{1'b1}};
			pad_pu_o <= {NPINS{1'b0}};
			pad_pd_o <= {NPINS{1'b0}};
			pad_weak_o <= {NPINS{1'b0}};
			pad_ie_o <= {NPINS{1'b0}};
			pad_lvttl_o <= {NPINS{1'b0}};
			pad_slow_o <= {NPINS{1'b0}};
		end else begin
			for (k = 0; k < NPINS; k = k + 1) begin
				if (upd[k]) begin
					pad_out_o[k] <= next_out[k];
					pad_oe_n_o[k] <= ~next_oe[k];
					pad_pu_o[k] <= next_pu[k];
					pad_pd_o[k] <= next_pd[k];
					pad_weak_o[k] <= next_weak[k];
					pad_ie_o[k] <= next_ie[k];
					pad_lvttl_o[k] <= lvttl_f[k];
					pad_slow_o[k] <= slow_f[k];
				end
			end
		end
	end

	// Three-stage sampler; a level counts once stages two and three agree
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= {NALL{1'b0}};
			sync2 <= {NALL{1'b0}};
			sync3 <= {NALL{1'b0}};
			ps <= {NALL{1'b0}};
		end else begin
			sync1 <= pin_ext;
			sync2 <= sync1;
			sync3 <= sync2;
			ps <= next_ps;
		end
	end

	assign agree = ~(sync2 ^ sync3);
	// Disabled inputs read as zero and cannot fire events
	assign next_ps = ((agree & sync3) | (~agree & ps)) & next_ie;
	assign evt = (next_ps ^ ps) & next_ie;
	assign ps_f = ps;
	assign periph_in_o = ps[NPINS-1:0];

	// Write channel: address and data may arrive in either order
	assign s_axi_awready_o = ~aw_got & ~s_axi_bvalid_o;
	assign s_axi_wready_o = ~w_got & ~s_axi_bvalid_o;
	assign do_wr = aw_got & w_got & ~s_axi_bvalid_o;
	assign wp = aw_addr[`GPB_PORT_LSB+2:`GPB_PORT_LSB];
	assign wr = aw_addr[`GPB_REG_LSB+2:`GPB_REG_LSB];
	assign wmap = ~|aw_addr[AW-1:`GPB_MAP_LSB];
	assign rp = s_axi_araddr_i[`GPB_PORT_LSB+2:`GPB_PORT_LSB];
	assign rr = s_axi_araddr_i[`GPB_REG_LSB+2:`GPB_REG_LSB];
	assign rmap = ~|s_axi_araddr_i[AW-1:`GPB_MAP_LSB];

	// Register image by port and index, shared by read and merge
	function [31:0] gpb_word;
		input [2:0] idx;
		input [7:0] b_dr;
		input [7:0] b_ps;
		input [31:0] w_dm;
		input [31:0] w_cfg;
		input [7:0] b_hold;
		input [7:0] b_msk;
		input [7:0] b_stat;
		input [7:0] b_sel;
		begin
			case (idx)
			`GPB_REG_DR: gpb_word = {24'h000000, b_dr};
			`GPB_REG_PS: gpb_word = {24'h000000, b_ps};
			`GPB_REG_DM: gpb_word = w_dm;
			`GPB_REG_CFG: gpb_word = w_cfg;
			`GPB_REG_HOLD: gpb_word = {24'h000000, b_hold};
			`GPB_REG_MSK: gpb_word = {24'h000000, b_msk};
			`GPB_REG_STAT: gpb_word = {24'h000000, b_stat};
			default: gpb_word = {24'h000000, b_sel};
			endcase
		end
	endfunction

	always @* begin
		cur_word = gpb_word(wr, dr[wp], ps_f[wp*8+:8], dm[wp],
			{slow[wp], lvttl[wp], outdis[wp], indis[wp]},
			hold[wp], msk[wp], stat[wp], sel[wp]);
		rd_word = gpb_word(rr, dr[rp], ps_f[rp*8+:8], dm[rp],
			{slow[rp], lvttl[rp], outdis[rp], indis[rp]},
			hold[rp], msk[rp], stat[rp], sel[rp]);
	end

	// Byte strobes merge new data into the current word
	assign wv = {s_axi_wdata_i[31:24] & {8{1'b0}}, 24'h000000}
		| {w_strb[3] ? w_data[31:24] : cur_word[31:24],
		w_strb[2] ? w_data[23:16] : cur_word[23:16],
		w_strb[1] ? w_data[15:8] : cur_word[15:8],
		w_strb[0] ? w_data[7:0] : cur_word[7:0]};

	// Write handshakes and response
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= {AW{1'b0}};
			w_data <= `GPB_RST_WORD;
			w_strb <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `GPB_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wmap ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Configuration writes; reset value of every mode field is disabled
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (kc = 0; kc < `GPB_NPORTS; kc = kc + 1) begin
				dr[kc] <= `GPB_RST_BYTE;
				dm[kc] <= `GPB_RST_WORD;
				indis[kc] <= `GPB_RST_BYTE;
				outdis[kc] <= `GPB_RST_BYTE;
				lvttl[kc] <= `GPB_RST_BYTE;
				slow[kc] <= `GPB_RST_BYTE;
				hold[kc] <= `GPB_RST_BYTE;
				msk[kc] <= `GPB_RST_BYTE;
				sel[kc] <= `GPB_RST_BYTE;
			end
		end else if (do_wr && wmap) begin
			case (wr)
			`GPB_REG_DR: dr[wp] <= wv[7:0] & wpm;
			`GPB_REG_DM: dm[wp] <= wv & wdm;
			`GPB_REG_CFG: begin
				indis[wp] <= wv[`GPB_CFG_INDIS_LSB+:8] & wpm;
				outdis[wp] <= wv[`GPB_CFG_OUTDIS_LSB+:8] & wpm;
				lvttl[wp] <= wv[`GPB_CFG_LVTTL_LSB+:8] & wpm;
				slow[wp] <= wv[`GPB_CFG_SLOW_LSB+:8] & wpm;
			end
			`GPB_REG_HOLD: hold[wp] <= wv[7:0] & wpm;
			`GPB_REG_MSK: msk[wp] <= wv[7:0] & wpm;
			`GPB_REG_SEL: sel[wp] <= wv[7:0] & wpm;
			default: begin
			end
			endcase
		end
	end

	// Pending flags: an event in the clearing cycle survives the clear
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (ks = 0; ks < `GPB_NPORTS; ks = ks + 1) begin
				stat[ks] <= `GPB_RST_BYTE;
			end
		end else begin
			for (ks = 0; ks < `GPB_NPORTS; ks = ks + 1) begin
				if (do_wr && wmap && wr == `GPB_REG_STAT
					&& wp == ks[2:0] && w_strb[0]) begin
					stat[ks] <= (stat[ks] & ~w_data[7:0])
						| evt[ks*8+:8];
				end else begin
					stat[ks] <= stat[ks] | evt[ks*8+:8];
				end
			end
		end
	end

	// Read channel: data registered at the address handshake
	assign s_axi_arready_o = ~s_axi_rvalid_o;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= `GPB_RST_WORD;
			s_axi_rresp_o <= `GPB_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rmap ? rd_word : `GPB_RST_WORD;
			s_axi_rresp_o <= rmap ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule // gpb_top

// File: gpb_top_props.sv
// Concurrent checks on pad control, pin state and port interrupts
`timescale 1ns/1ns
module gpb_chk #(parameter NPINS = 55) (
	input wire clk_i,
	input wire rst_i,
	input wire s_axi_bvalid_o,
	input wire [1:0] s_axi_bresp_o,
	input wire sleep_hold_i,
	input wire [NPINS-1:0] pad_in_i,
	input wire [NPINS-1:0] pad_out_o,
	input wire [NPINS-1:0] pad_oe_n_o,
	input wire [NPINS-1:0] pad_pu_o,
	input wire [NPINS-1:0] pad_pd_o,
	input wire [NPINS-1:0] pad_ie_o,
	input wire [NPINS-1:0] periph_in_o,
	input wire [7:0] port_irq_o,
	input wire irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
// Pins come out of reset released
chk_reset_off: assert property ($fell(rst_i) |->
	&pad_oe_n_o && (pad_ie_o | pad_pu_o | pad_pd_o) == '0)
	else $error("pins not released after reset");
chk_irq_or: assert property (irq_o == |port_irq_o)
	else $error("irq is not the OR of port requests");
chk_port7_idle: assert property (port_irq_o[7] == 1'b0)
	else $error("absent port raised a request");
// Pulled modes only drive against their pull
chk_pu_low: assert property ((~pad_oe_n_o & pad_pu_o & pad_out_o) == '0)
	else $error("pull-up pin driven high");
chk_pd_high: assert property ((~pad_oe_n_o & pad_pd_o & ~pad_out_o) == '0)
	else $error("pull-down pin driven low");
// Disabled input reads low; frozen pads may lag the enable
chk_ie_state: assert property (!$past(sleep_hold_i) |->
	(periph_in_o & ~pad_ie_o) == '0)
	else $error("pin state high with input disabled");
chk_pin_rise: assert property ((periph_in_o & ~$past(periph_in_o) &
	~$past(pad_in_i, 4)) == '0)
	else $error("pin state rose without synchronised pin");
chk_irq_clear: assert property (|($past(port_irq_o) & ~port_irq_o)
	|-> $rose(s_axi_bvalid_o))
	else $error("port request fell without a register write");
cover property (irq_o);
cover property (sleep_hold_i);
cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule // gpb_chk
bind gpb_top gpb_chk #(.NPINS(NPINS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bresp_o(s_axi_bresp_o),
	.sleep_hold_i(sleep_hold_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
	.pad_oe_n_o(pad_oe_n_o), .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o),
	.pad_ie_o(pad_ie_o), .periph_in_o(periph_in_o),
	.port_irq_o(port_irq_o), .irq_o(irq_o));

// File: gpb_pins.sv
// Board model: resolves each pin from device drive, pulls and board drive
`timescale 1ns/1ns
module gpb_pins #(parameter NPINS = 55) (
	input wire clk_i,
	input wire [NPINS-1:0] out_i,
	input wire [NPINS-1:0] oe_n_i,
	input wire [NPINS-1:0] pu_i,
	input wire [NPINS-1:0] pd_i,
	input wire [NPINS-1:0] ext_en_i,
	input wire [NPINS-1:0] ext_val_i,
	output wire [NPINS-1:0] pin_o
);
reg [NPINS-1:0] flt = '0;
// Floating pins toggle so a stale level never passes as valid
always @(posedge clk_i) begin
	flt <= ~flt;
end
// Device drive wins, then board drive, then pulls
assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_val_i) |
	(oe_n_i & ~ext_en_i & (pu_i | (~pd_i & flt)));
endmodule // gpb_pins

// File: gpb_top_test.sv
// Register-level testbench of the GPIO port block
`timescale 1ns/1ns
`include "gpb_consts.vh"
module gpb_top_test;
reg clk_i = 1'b0;
reg rst_i = 1'b1;
reg [11:0] awa = 12'h000, ara = 12'h000;
reg [31:0] wd = 32'h00000000, rv;
reg awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, slp = 1'b0;
reg [54:0] pout = '0, poe = '0, xv = '0, xen = 55'h10000;
wire awr, wr_r, bv, arr, rvl, irq;
wire [1:0] br, rr;
wire [31:0] rd_d;
wire [54:0] pin, out, oen, pu, pd, wk, ie, lv, sl, ps;
wire [7:0] pirq;
// Seen {oe_n, driven value, pu, pd, weak, ie} of pin 8
wire [5:0] p8 = {oen[8], ~oen[8] & out[8], pu[8], pd[8],
	wk[8] & (pu[8] | pd[8]), ie[8]};
integer failures = 0, checks_done = 0, m, d, n;
`define CHK(nm, e, g) begin checks_done = checks_done + 1; \
	if ((g) !== (e)) begin failures = failures + 1; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
always #5 clk_i = ~clk_i;
gpb_top dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa),
	.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
	.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
	.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
	.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
	.s_axi_rdata_o(rd_d), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rvl),
	.s_axi_rready_i(rrdy), .sleep_hold_i(slp), .pad_in_i(pin),
	.pad_out_o(out), .pad_oe_n_o(oen), .pad_pu_o(pu), .pad_pd_o(pd),
	.pad_weak_o(wk), .pad_ie_o(ie), .pad_lvttl_o(lv), .pad_slow_o(sl),
	.periph_out_i(pout), .periph_oe_i(poe), .periph_in_o(ps),
	.port_irq_o(pirq), .irq_o(irq));
gpb_pins u_pins (.clk_i(clk_i), .out_i(out), .oe_n_i(oen), .pu_i(pu),
	.pd_i(pd), .ext_en_i(xen), .ext_val_i(xv), .pin_o(pin));
task conclude;
	begin
		if (failures == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end
endtask
function [11:0] ad(input [2:0] pt, input [2:0] r);
	ad = {4'h0, pt, r, 2'b00};
endfunction
function [1:0] eresp(input [11:0] a);
	eresp = (a >= 12'h100) ? `GPB_RESP_SLVERR : `GPB_RESP_OKAY;
endfunction
// Expected {oe_n, driven value, pu, pd, weak, ie} of one pin
function [5:0] emode(input [3:0] c, input b);
	reg o;
	begin
		case (c)
			4'h2: o = 1'b0;
			4'h3, 4'h5, 4'h7: o = b;
			4'h4, 4'h6, 4'h8: o = ~b;
			default: o = 1'b1;
		endcase
		emode = {o, ~o & b, c == 3 || c == 5, c == 4 || c == 6,
			c == 5 || c == 6, c > 0 && c < 9};
	end
endfunction
task tick(input integer k);
	repeat (k) @(posedge clk_i);
endtask
// Address and data offered together, each dropped once taken
task wr(input [11:0] a, input [31:0] dt);
	begin
		@(posedge clk_i);
		awa <= a; wd <= dt; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
			n = n + 1;
		end while (bv !== 1'b1 && n < 40);
		if (n >= 40) begin failures = failures + 1; conclude; end
		`CHK("bresp", eresp(a), br)
		brdy <= 1'b0;
	end
endtask
task rchk(input [11:0] a, input [31:0] e);
	begin
		@(posedge clk_i);
		ara <= a; arv <= 1'b1; rrdy <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
			n = n + 1;
		end while (rvl !== 1'b1 && n < 40);
		if (n >= 40) begin failures = failures + 1; conclude; end
		`CHK("rresp", eresp(a), rr)
		`CHK("rdata", e, rd_d)
		rrdy <= 1'b0;
	end
endtask
initial begin
	tick(3);
	rst_i <= 1'b0;
	tick(1);
	`CHK("oe_n", {55{1'b1}}, oen)
	`CHK("pads", 55'h0, ie | pu | pd | out)
	for (m = 0; m < 8; m = m + 1) rchk(ad(0, m), 0);
	// Every drive code with both data values on pin 8
	for (d = 0; d < 2; d = d + 1) begin
		wr(ad(1, 0), d);
		for (m = 0; m < 10; m = m + 1) begin
			wr(ad(1, 2), m);
			tick(2);
			`CHK("mode", emode(m, d), p8)
		end
	end
	wr(ad(1, 2), 2);
	wr(ad(1, 3), 32'h01010100);
	tick(2);
	`CHK("cfg", 4'hF, {lv[8], sl[8], oen[8], ie[8]})
	wr(ad(1, 3), 32'h00000001);
	tick(6);
	`CHK("indis", 4'h0, {lv[8], sl[8], oen[8], ie[8]})
	rchk(ad(1, 1), 0);
	// Pin 16 events, mask and clear; board drives it
	wr(ad(2, 2), 1);
	wr(ad(2, 5), 1);
	xv[16] <= 1'b1;
	// Reads right after an edge see values from before that edge's updates
	tick(4);
	`CHK("sync3", 1'b0, ps[16])
	tick(1);
	`CHK("sync4", 1'b1, ps[16])
	`CHK("pirq", 9'h104, {irq, pirq})
	rchk(ad(2, 1), 1);
	wr(ad(2, 5), 0);
	`CHK("masked", 1'b0, irq)
	rchk(ad(2, 6), 1);
	wr(ad(2, 6), 1);
	rchk(ad(2, 6), 0);
	xv[16] <= 1'b0;
	tick(6);
	wr(ad(2, 5), 1);
	`CHK("fall", 9'h104, {irq, pirq})
	wr(ad(2, 6), 1);
	`CHK("clear", 1'b0, irq)
	// Pin 24 handed to its peripheral
	wr(ad(3, 2), 2);
	wr(ad(3, 7), 1);
	pout[24] <= 1'b1;
	poe[24] <= 1'b1;
	tick(3);
	`CHK("mux", 2'b01, {oen[24], out[24]})
	poe[24] <= 1'b0;
	tick(3);
	`CHK("muxoe", 1'b1, oen[24])
	// Pin 32 held, pin 33 free, through sleep
	wr(ad(4, 2), 32'h22);
	wr(ad(4, 0), 3);
	wr(ad(4, 4), 1);
	slp <= 1'b1;
	wr(ad(4, 0), 0);
	tick(2);
	`CHK("hold", 2'b01, {out[33], out[32]})
	slp <= 1'b0;
	tick(3);
	`CHK("wake", 1'b0, out[32])
	wr(ad(6, 0), 32'hFF);
	rchk(ad(6, 0), 32'h7F);
	wr(ad(7, 0), 32'hFF);
	rchk(ad(7, 0), 0);
	wr(12'h100, 1);
	rchk(12'h100, 0);
	wr(ad(2, 1), 32'hFF);
	rchk(ad(2, 1), 0);
	conclude;
end
endmodule // gpb_top_test
